// ==== asbc_pkg.sv ====
/*
 * asbc_pkg: shared constants and types for the converter sequencing and
 * buffer control block. Assumes a 16-bit register port addressed by word
 * index and a single 200 MHz system clock.
 */
package asbc_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ASBC_ADDR_SEQ_CTRL = 3'h0;
    localparam logic [2:0] ASBC_ADDR_BUF_SIZE = 3'h1;
    localparam logic [2:0] ASBC_ADDR_IRQ_STAT = 3'h2;
    localparam logic [2:0] ASBC_ADDR_IRQ_CLR = 3'h3;
    localparam logic [2:0] ASBC_ADDR_IRQ_EN = 3'h4;
    localparam logic [2:0] ASBC_ADDR_STATUS = 3'h5;

    // field positions in the sequence control register
    localparam int ASBC_CHAN_CNT_LSB = 8;
    localparam int ASBC_FILL_BIT = 7;
    localparam int ASBC_CPE_LSB = 2;
    localparam int ASBC_SPLIT_BIT = 1;
    // writable mask of the sequence control register (fill status read-only)
    localparam logic [15:0] ASBC_SEQ_WMASK = 16'hE73F;
    // only the low three bits of the buffer size register exist
    localparam logic [15:0] ASBC_BUF_WMASK = 16'h0007;
    localparam logic [15:0] ASBC_SEQ_RESET = 16'h0000;
    localparam logic [15:0] ASBC_BUF_RESET = 16'h0000;
    localparam logic [3:0] ASBC_CNT_RESET = 4'h0;

    // interrupt status bit positions
    localparam int ASBC_EV_STEP = 0;
    localparam int ASBC_EV_HALF = 1;
    localparam int ASBC_EV_NUM = 2;

    typedef enum logic [2:0] {
        ASBC_IDLE = 3'b001,
        ASBC_RUN = 3'b010,
        ASBC_STEP = 3'b100
    } asbc_state_t;

    // register port request, grouped
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } asbc_req_t;

    // per-step answer to the dma side
    typedef struct packed {
        logic [3:0] channel_mask;
        logic [7:0] words_per_input;
        logic fill_half;
    } asbc_dma_t;
endpackage

// ==== asbc_ctrl.sv ====
/*
 * asbc_ctrl: sequencing and buffer control of the converter. Holds the
 * sequence control and buffer size registers, counts finished conversions,
 * steps the dma address, alternates buffer halves and raises an interrupt.
 *
 * Register indices on the plain port:
 *   0 sequence control, 1 buffer size, 2 interrupt status (read only),
 *   3 interrupt clear (write only, a one clears), 4 interrupt enable,
 *   5 sequencer status (state in bits 6:4, group count in bits 3:0).
 *
 * Sequence control layout:
 *   15:13 reference setting, stored only
 *   10    scan select, stored only
 *   9:8   channel count code
 *   7     fill half status, read only
 *   5:2   conversions per event, code n means every n+1 conversions
 *   1     split buffer mode
 *   0     alternate sample mode, stored only
 *
 * Buffer size layout:
 *   2:0   words per input code, two to the power of the code
 *   15:3  not built, read as zero
 *
 * Timing:
 *   a write lands at the edge that samples the strobe;
 *   read data stand in the cycle after the read strobe, zero otherwise;
 *   the dma step pulse and the status bits follow a boundary by one edge;
 *   the dma word follows a register or half change by one edge.
 *
 * Limitations:
 *   the first conversion after reset only wakes the sequencer, but with a
 *   nonzero code it is still counted, so the first group is not shortened;
 *   changing the conversions per event code mid group does not restart
 *   the group; a count already past the new code wraps at the next done.
 *
 * Assumes conv_done_i is a one-cycle pulse from logic on the same clock and
 * that the register master never strobes read and write together.
 */
// Decided for this implementation: the register offsets and the address-and-strobe port.
// Summary of operation
// - channel count selects one, two or four sample-holds
// - fill status shows half being written
// - step after programmed number of conversions
// - split mode alternates halves per interrupt
// - words per input is two to field
// - upper buffer size bits read zero
module asbc_ctrl
    import asbc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire asbc_req_t req_i,
    output logic [15:0] rdata_o,
    input wire logic conv_done_i,
    output asbc_dma_t dma_o,
    output logic dma_step_o,
    output logic irq_o
);
    logic [15:0] seq_ctrl;
    logic [15:0] buf_size;
    logic [ASBC_EV_NUM-1:0] irq_stat;
    logic [ASBC_EV_NUM-1:0] irq_en;
    logic [3:0] conv_cnt;
    logic fill_half;
    asbc_state_t state;
    asbc_state_t next_state;
    logic [1:0] chan_sel;
    logic [3:0] per_event;
    logic split_mode;
    logic boundary;
    logic [ASBC_EV_NUM-1:0] events;
    logic [ASBC_EV_NUM-1:0] clr_hit;
    logic [3:0] chan_mask;
    logic [7:0] words_per_input;
    logic [3:0] next_conv_cnt;
    logic next_fill_half;
    logic [15:0] next_rdata;
    logic [15:0] status_word;
    logic wr_seq;
    logic wr_buf;
    logic wr_clr;
    logic wr_en;

    // register write decodes, one per writable index
    assign wr_seq = req_i.wr && (req_i.addr == ASBC_ADDR_SEQ_CTRL);
    assign wr_buf = req_i.wr && (req_i.addr == ASBC_ADDR_BUF_SIZE);
    assign wr_clr = req_i.wr && (req_i.addr == ASBC_ADDR_IRQ_CLR);
    assign wr_en = req_i.wr && (req_i.addr == ASBC_ADDR_IRQ_EN);

    // configuration fields taken straight from the stored register
    assign chan_sel = seq_ctrl[ASBC_CHAN_CNT_LSB +: 2];
    assign per_event = seq_ctrl[ASBC_CPE_LSB +: 4];
    assign split_mode = seq_ctrl[ASBC_SPLIT_BIT];

    // boundary when the count reaches the programmed value; code n means n+1 ops
    assign boundary = (state == ASBC_RUN) && conv_done_i && (conv_cnt == per_event);

    // control registers; software writes are masked to existing bits
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            seq_ctrl <= ASBC_SEQ_RESET;
            buf_size <= ASBC_BUF_RESET;
        end else begin
            if (wr_seq) begin
                seq_ctrl <= req_i.wdata & ASBC_SEQ_WMASK;
            end
            if (wr_buf) begin
                buf_size <= req_i.wdata & ASBC_BUF_WMASK;
            end
        end
    end

    // per-channel enable; channels 2 and 3 need the upper code bit
    genvar ci;
    generate
        for (ci = 0; ci < 4; ci++) begin : g_chan
            if (ci == 0) begin : g_first
                assign chan_mask[ci] = 1'b1;
            end else if (ci == 1) begin : g_pair
                assign chan_mask[ci] = chan_sel[1] | chan_sel[0];
            end else begin : g_quad
                assign chan_mask[ci] = chan_sel[1];
            end
        end
    endgenerate

    // buffer words per input; the shift cannot leave eight bits
    assign words_per_input = 8'h01 << buf_size[2:0];

    // simple sequencer: idle until first conversion, step pulse one cycle
    always_comb begin
        next_state = state;
        case (state)
            ASBC_IDLE: begin
                if (conv_done_i) next_state = ASBC_RUN;
            end
            ASBC_RUN: begin
                if (boundary) next_state = ASBC_STEP;
            end
            ASBC_STEP: begin
                next_state = ASBC_RUN;
            end
            default: begin
                next_state = ASBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ASBC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // conversion count; with a nonzero code a done in idle or step still counts so none is lost
    always_comb begin
        next_conv_cnt = conv_cnt;
        if (conv_done_i) begin
            if (boundary || (conv_cnt >= per_event)) begin
                next_conv_cnt = ASBC_CNT_RESET;
            end else begin
                next_conv_cnt = conv_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conv_cnt <= ASBC_CNT_RESET;
        end else begin
            conv_cnt <= next_conv_cnt;
        end
    end

    // half pointer: toggles per boundary in split mode, else parked at start
    always_comb begin
        next_fill_half = fill_half;
        if (!split_mode) begin
            next_fill_half = 1'b0;
        end else if (boundary) begin
            next_fill_half = ~fill_half;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fill_half <= 1'b0;
        end else begin
            fill_half <= next_fill_half;
        end
    end

    // dma outputs come from flip-flops
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dma_o <= '0;
            dma_step_o <= 1'b0;
        end else begin
            dma_o.channel_mask <= chan_mask;
            dma_o.words_per_input <= words_per_input;
            dma_o.fill_half <= fill_half;
            dma_step_o <= boundary;
        end
    end

    // events: every step, and a half swap in split mode
    assign events[ASBC_EV_STEP] = boundary;
    assign events[ASBC_EV_HALF] = boundary && split_mode;

    // clear request per status bit, only on a write to the clear index
    assign clr_hit = wr_clr ? req_i.wdata[ASBC_EV_NUM-1:0] : '0;

    // sticky status per event; set beats a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < ASBC_EV_NUM; gi++) begin : g_irq
            always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    irq_stat[gi] <= 1'b0;
                end else if (events[gi]) begin
                    irq_stat[gi] <= 1'b1;
                end else if (clr_hit[gi]) begin
                    irq_stat[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_en <= '0;
        end else if (wr_en) begin
            irq_en <= req_i.wdata[ASBC_EV_NUM-1:0];
        end
    end

    assign irq_o = |(irq_stat & irq_en);

    // sequencer status word for debug reads
    assign status_word = {9'h000, state, conv_cnt};

    // read mux; a zero word when no read is asked keeps the bus quiet
    always_comb begin
        next_rdata = 16'h0000;
        if (req_i.rd) begin
            case (req_i.addr)
                ASBC_ADDR_SEQ_CTRL: begin
                    next_rdata = seq_ctrl | (16'(fill_half) << ASBC_FILL_BIT);
                end
                ASBC_ADDR_BUF_SIZE: begin
                    next_rdata = buf_size;
                end
                ASBC_ADDR_IRQ_STAT: begin
                    next_rdata = {14'h0000, irq_stat};
                end
                ASBC_ADDR_IRQ_EN: begin
                    next_rdata = {14'h0000, irq_en};
                end
                ASBC_ADDR_STATUS: begin
                    next_rdata = status_word;
                end
                default: begin
                    next_rdata = 16'h0000;
                end
            endcase
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end
endmodule

// ==== asbc_ctrl_monitor.sv ====
/* asbc_mon: port checks of asbc_ctrl.
   Assumes one clock; config is held steady within a group. */
module asbc_mon
    import asbc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire asbc_req_t req_i,
    input wire logic [15:0] rdata_o,
    input wire logic conv_done_i,
    input wire asbc_dma_t dma_o,
    input wire logic dma_step_o,
    input wire logic irq_o
);
    wire logic wseq = req_i.wr && req_i.addr == ASBC_ADDR_SEQ_CTRL;
    wire logic wbuf = req_i.wr && req_i.addr == ASBC_ADDR_BUF_SIZE;
    logic [3:0] cpe;
    logic split, seen;
    logic [4:0] cnt;
    // shadow config; a write voids the group in flight, so its length is not judged
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) {cpe, split, seen, cnt} <= '0;
        else begin
            if (wseq) {cpe, split, seen} <= {req_i.wdata[5:2], req_i.wdata[1], 1'b0};
            else if (dma_step_o) seen <= 1'b1;
            cnt <= dma_step_o ? 5'(conv_done_i) : cnt + 5'(conv_done_i);
        end
    end
    function automatic logic [3:0] fmask(input logic [1:0] c);
        return c[1] ? 4'hF : {2'h0, c[0], 1'b1};
    endfunction
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    chan_mask_a: assert property (wseq |-> ##2
        dma_o.channel_mask == fmask($past(req_i.wdata[9:8], 2))) else $error("bad mask");
    words_len_a: assert property (wbuf |-> ##2
        dma_o.words_per_input == 8'h01 << $past(req_i.wdata[2:0], 2)) else $error("bad words");
    buf_zero_a: assert property (req_i.rd && req_i.addr == ASBC_ADDR_BUF_SIZE |=>
        rdata_o[15:3] == 13'h0) else $error("upper bits set");
    fill_rd_a: assert property (req_i.rd && req_i.addr == ASBC_ADDR_SEQ_CTRL |=>
        rdata_o[ASBC_FILL_BIT] == dma_o.fill_half) else $error("fill status mismatch");
    group_len_a: assert property (dma_step_o && seen |-> cnt == 5'(cpe) + 5'h01)
        else $error("wrong group length");
    step_src_a: assert property (dma_step_o |-> $past(conv_done_i)) else $error("stray step");
    half_tog_a: assert property (dma_step_o && split |=>
        dma_o.fill_half != $past(dma_o.fill_half)) else $error("half kept");
    half_hold_a: assert property (dma_step_o && !split |=> $stable(dma_o.fill_half))
        else $error("half moved");
    cover property (dma_step_o && split);
    cover property (irq_o);
    cover property (wbuf);
endmodule
bind asbc_ctrl asbc_mon mon_u (.clk_sys_i, .sys_rst_i, .req_i, .rdata_o, .conv_done_i,
    .dma_o, .dma_step_o, .irq_o);

// ==== asbc_dma_model.sv ====
/* dma-side model: pulses conversion done, counts address steps.
   Assumes it shares the block clock. */
module asbc_dma_model
(
    input wire logic clk_i,
    input wire logic dma_step_i,
    output logic conv_done_o,
    output int steps_o
);
    initial conv_done_o = 1'b0;
    initial steps_o = 0;
    // count every address step the block asks for
    always @(posedge clk_i) if (dma_step_i) steps_o <= steps_o + 1;
    // n one-cycle pulses; gap plus one idle cycles between them models a slow converter
    task automatic run(input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i) conv_done_o <= 1'b1;
            @(posedge clk_i) conv_done_o <= 1'b0;
            repeat (gap) @(posedge clk_i);
        end
    endtask
endmodule

// ==== test_adc_sequencing_buffer_control.sv ====
/* bench: asbc_ctrl against the dma model over the register port.
   Assumes a 200 MHz clock and bus strobes of one cycle. */
module test_adc_sequencing_buffer_control
    import asbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    asbc_req_t req = '0;
    logic [15:0] rdata, d;
    logic conv_done, dma_step, irq;
    asbc_dma_t dma;
    int steps, error_cnt = 0, cmp_count = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    asbc_ctrl dut_u (.clk_sys_i, .sys_rst_i, .req_i(req), .rdata_o(rdata),
        .conv_done_i(conv_done), .dma_o(dma), .dma_step_o(dma_step), .irq_o(irq));
    asbc_dma_model dma_u (.clk_i(clk_sys_i), .dma_step_i(dma_step), .conv_done_o(conv_done),
        .steps_o(steps));
    // compare and bus tasks; strobes change just after an edge
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_sys_i) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i) req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys_i) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i) req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // reset value, unbuilt upper bits, unmapped address
    task automatic t_regs;
        rd(ASBC_ADDR_BUF_SIZE);
        chk(d, ASBC_BUF_RESET);
        wr(ASBC_ADDR_BUF_SIZE, 16'hFFFF);
        rd(ASBC_ADDR_BUF_SIZE);
        chk(d, 16'h0007);
        rd(3'h7);
        chk(d, 16'h0000);
    endtask
    // every channel-count and words-per-input code
    task automatic t_fields;
        for (int i = 0; i < 8; i++) begin
            wr(ASBC_ADDR_SEQ_CTRL, 16'(i % 4) << ASBC_CHAN_CNT_LSB);
            wr(ASBC_ADDR_BUF_SIZE, 16'(i));
            repeat (2) @(posedge clk_sys_i);
            #1 chk(16'(dma.channel_mask), (i % 4) < 2 ? 16'((i % 4) * 2 + 1) : 16'h000F);
            chk(16'(dma.words_per_input), 16'h0001 << i);
        end
    endtask
    // one group of n+1 conversions gives one step; split mode swaps the half
    task automatic t_group(input int n, input logic sp);
        int s;
        logic h;
        wr(ASBC_ADDR_SEQ_CTRL, 16'(n) << ASBC_CPE_LSB | 16'(sp) << ASBC_SPLIT_BIT);
        dma_u.run(1, 0);
        repeat (4) @(posedge clk_sys_i);
        rd(ASBC_ADDR_SEQ_CTRL);
        s = steps;
        h = d[ASBC_FILL_BIT];
        dma_u.run(n + 1, sp ? 0 : 3);
        repeat (4) @(posedge clk_sys_i);
        chk(16'(steps - s), 16'h0001);
        rd(ASBC_ADDR_SEQ_CTRL);
        chk(16'(d[ASBC_FILL_BIT]), 16'(h ^ sp));
    endtask
    // interrupt masked, then enabled, then cleared
    task automatic t_irq;
        wr(ASBC_ADDR_IRQ_CLR, 16'h0003);
        dma_u.run(2, 1);
        repeat (4) @(posedge clk_sys_i);
        chk(16'(irq), 16'h0000);
        rd(ASBC_ADDR_IRQ_STAT);
        chk(d & 16'h0001, 16'h0001);
        wr(ASBC_ADDR_IRQ_EN, 16'h0001);
        #1 chk(16'(irq), 16'h0001);
        wr(ASBC_ADDR_IRQ_CLR, 16'h0001);
        #1 chk(16'(irq), 16'h0000);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_regs;
        t_fields;
        t_group(15, 1'b1);
        t_group(1, 1'b1);
        t_group(1, 1'b0);
        t_irq;
        give_verdict;
    end
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #20us;
        error_cnt++;
        give_verdict;
    end
endmodule
